// *** rtl/rfc_params.svh ***
// constants for the residual fault classifier: register offsets, reset values, timing
// assumes a 250 MHz clock and 10-bit unsigned converter codes
`ifndef RFC_PARAMS_SVH
`define RFC_PARAMS_SVH

`define RFC_CLK_MHZ          250
`define RFC_WINDOW_MS        13
`define RFC_WINDOW_CYCLES    (`RFC_WINDOW_MS * `RFC_CLK_MHZ * 1000)
`define RFC_SAMPLE_US        100
`define RFC_SAMPLE_CYCLES    (`RFC_SAMPLE_US * `RFC_CLK_MHZ)

`define RFC_OFS_CTRL         6'h00
`define RFC_OFS_STATUS       6'h04
`define RFC_OFS_AC_THR       6'h08
`define RFC_OFS_DC_THR       6'h0c
`define RFC_OFS_ZERO_LVL     6'h10
`define RFC_OFS_HYST         6'h14
`define RFC_OFS_WINDOW       6'h18
`define RFC_OFS_EXTREMES     6'h1c
`define RFC_OFS_IRQ_STAT     6'h20
`define RFC_OFS_IRQ_MASK     6'h24

`define RFC_RST_AC_THR       10'h199
`define RFC_RST_DC_THR       10'h088
`define RFC_RST_ZERO_LVL     10'h008
`define RFC_RST_HYST         10'h010
`define RFC_RST_ENABLE       1'b1

`define RFC_IRQ_DC           0
`define RFC_IRQ_AC           1
`define RFC_IRQ_RELEASE      2
`define RFC_IRQ_BITS         3

`endif

// *** rtl/rfc_pkg.sv ***
// types for the residual fault classifier
// shared by the core and by anything that wants its state encodings
package rfc_pkg;
    typedef enum logic [1:0] {
        RFC_IDLE,
        RFC_MONITOR,
        RFC_TRIPPED
    } rfc_state_t;

    typedef enum logic [1:0] {
        RFC_FAULT_NONE,
        RFC_FAULT_DC,
        RFC_FAULT_AC
    } rfc_fault_t;

    typedef struct packed {
        logic [9:0] ac_thr;
        logic [9:0] dc_thr;
        logic [9:0] zero_lvl;
        logic [9:0] hyst;
    } rfc_cfg_t;

    typedef struct packed {
        logic [9:0] smax;
        logic [9:0] smin;
    } rfc_ext_t;
endpackage : rfc_pkg

// *** rtl/rfc_core.sv ***
// residual fault classifier: converter sample requests, window tracking,
// ac/dc classification, trip output and a classic wishbone register slave
// assumes adc_data_i comes from logic on clk_i, valid for one cycle with adc_valid_i
`include "rfc_params.svh"
`timescale 1ns/1ns
`default_nettype none

module rfc_core
    import rfc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             adc_req_o,
    input  wire logic        adc_valid_i,
    input  wire logic [9:0]  adc_data_i,
    output logic             trip_o,
    output logic             irq_o
);
    localparam logic [31:0] WINDOW_RST = 32'(`RFC_WINDOW_CYCLES);
    localparam logic [31:0] SAMPLE_PER = 32'(`RFC_SAMPLE_CYCLES);

    rfc_state_t  state;
    rfc_fault_t  fault;
    rfc_cfg_t    cfg;
    rfc_ext_t    ext;
    logic [31:0] window_len;
    logic [31:0] win_cnt;
    logic [31:0] smp_cnt;
    logic        enable;
    logic [`RFC_IRQ_BITS-1:0] irq_stat;
    logic [`RFC_IRQ_BITS-1:0] irq_mask;
    logic [`RFC_IRQ_BITS-1:0] irq_evt;

    logic        wb_hit;
    logic        wb_wr;
    logic [9:0]  entry_lvl;
    logic [9:0]  release_lvl;
    logic        win_end;
    logic        is_dc;
    logic        is_ac;
    logic        released;
    logic [9:0]  next_max;
    logic [9:0]  next_min;

    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr  = wb_hit && wb_we_i && wb_sel_i[0];

    // lower threshold starts monitoring so neither fault type slips past
    assign entry_lvl = (cfg.ac_thr < cfg.dc_thr) ? cfg.ac_thr : cfg.dc_thr;

    // guard against hysteresis larger than the level itself
    assign release_lvl = (entry_lvl > cfg.hyst) ? entry_lvl - cfg.hyst : 10'h000;

    assign win_end  = (state == RFC_MONITOR) && (win_cnt >= window_len);
    assign is_dc    = ext.smin > cfg.dc_thr;
    assign is_ac    = (ext.smin <= cfg.zero_lvl) && (ext.smax > cfg.ac_thr);
    assign released = (state == RFC_TRIPPED) && adc_valid_i && (adc_data_i < release_lvl);

    // extremes include the sample taken in the current cycle
    assign next_max = (adc_valid_i && adc_data_i > ext.smax) ? adc_data_i : ext.smax;
    assign next_min = (adc_valid_i && adc_data_i < ext.smin) ? adc_data_i : ext.smin;

    // sample request pacing, runs in every state so monitoring sees fresh data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            smp_cnt   <= 32'h0000_0000;
            adc_req_o <= 1'b0;
        end else if (smp_cnt >= SAMPLE_PER - 32'h0000_0001) begin
            smp_cnt   <= 32'h0000_0000;
            adc_req_o <= enable;
        end else begin
            smp_cnt   <= smp_cnt + 32'h0000_0001;
            adc_req_o <= 1'b0;
        end
    end

    // classification state machine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= RFC_IDLE;
        end else begin
            case (state)
                RFC_IDLE: begin
                    if (enable && adc_valid_i && adc_data_i > entry_lvl) begin
                        state <= RFC_MONITOR;
                    end
                end
                RFC_MONITOR: begin
                    if (win_end) begin
                        if (is_dc || is_ac) begin
                            state <= RFC_TRIPPED;
                        end else begin
                            state <= RFC_IDLE;
                        end
                    end
                end
                RFC_TRIPPED: begin
                    if (released) begin
                        state <= RFC_IDLE;
                    end
                end
                default: begin
                    state <= RFC_IDLE;
                end
            endcase
        end
    end

    // window counter from monitor entry
    always_ff @(posedge clk_i) begin
        if (rst_i || state != RFC_MONITOR) begin
            win_cnt <= 32'h0000_0001;
        end else begin
            win_cnt <= win_cnt + 32'h0000_0001;
        end
    end

    // extremes: seeded from the entry sample, cleared back to idle values on other idle cycles, tracked in monitor, held once the window ends
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext.smax <= 10'h000;
            ext.smin <= 10'h3ff;
        end else if (state == RFC_IDLE) begin
            if (enable && adc_valid_i && adc_data_i > entry_lvl) begin
                ext.smax <= adc_data_i;
                ext.smin <= adc_data_i;
            end else begin
                ext.smax <= 10'h000;
                ext.smin <= 10'h3ff;
            end
        end else if (state == RFC_MONITOR && !win_end) begin
            ext.smax <= next_max;
            ext.smin <= next_min;
        end
    end

    // trip output and stored fault type
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trip_o <= 1'b0;
            fault  <= RFC_FAULT_NONE;
        end else if (win_end && is_dc) begin
            trip_o <= 1'b1;
            fault  <= RFC_FAULT_DC;
        end else if (win_end && is_ac) begin
            trip_o <= 1'b1;
            fault  <= RFC_FAULT_AC;
        end else if (released) begin
            trip_o <= 1'b0;
        end
    end

    // software settings
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg.ac_thr   <= `RFC_RST_AC_THR;
            cfg.dc_thr   <= `RFC_RST_DC_THR;
            cfg.zero_lvl <= `RFC_RST_ZERO_LVL;
            cfg.hyst     <= `RFC_RST_HYST;
            window_len   <= WINDOW_RST;
            enable       <= `RFC_RST_ENABLE;
            irq_mask     <= '0;
        end else if (wb_wr) begin
            case (wb_adr_i)
                `RFC_OFS_CTRL:     enable       <= wb_dat_i[0];
                `RFC_OFS_AC_THR:   cfg.ac_thr   <= wb_dat_i[9:0];
                `RFC_OFS_DC_THR:   cfg.dc_thr   <= wb_dat_i[9:0];
                `RFC_OFS_ZERO_LVL: cfg.zero_lvl <= wb_dat_i[9:0];
                `RFC_OFS_HYST:     cfg.hyst     <= wb_dat_i[9:0];
                `RFC_OFS_WINDOW:   window_len   <= wb_dat_i;
                `RFC_OFS_IRQ_MASK: irq_mask     <= wb_dat_i[`RFC_IRQ_BITS-1:0];
                default: begin
                end
            endcase
        end
    end

    // sticky events, set wins over a write-one clear
    always_comb begin
        irq_evt                   = '0;
        irq_evt[`RFC_IRQ_DC]      = win_end && is_dc;
        irq_evt[`RFC_IRQ_AC]      = win_end && !is_dc && is_ac;
        irq_evt[`RFC_IRQ_RELEASE] = released;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= '0;
        end else if (wb_wr && wb_adr_i == `RFC_OFS_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~wb_dat_i[`RFC_IRQ_BITS-1:0]) | irq_evt;
        end else begin
            irq_stat <= irq_stat | irq_evt;
        end
    end

    assign irq_o = |(irq_stat & irq_mask);

    // bus answer one cycle after the request, unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h0000_0000;
            if (wb_hit && !wb_we_i) begin
                case (wb_adr_i)
                    `RFC_OFS_CTRL:     wb_dat_o <= {31'h0, enable};
                    `RFC_OFS_STATUS:   wb_dat_o <= {26'h0, fault, state, 1'b0, trip_o};
                    `RFC_OFS_AC_THR:   wb_dat_o <= {22'h0, cfg.ac_thr};
                    `RFC_OFS_DC_THR:   wb_dat_o <= {22'h0, cfg.dc_thr};
                    `RFC_OFS_ZERO_LVL: wb_dat_o <= {22'h0, cfg.zero_lvl};
                    `RFC_OFS_HYST:     wb_dat_o <= {22'h0, cfg.hyst};
                    `RFC_OFS_WINDOW:   wb_dat_o <= window_len;
                    `RFC_OFS_EXTREMES: wb_dat_o <= {6'h0, ext.smax, 6'h0, ext.smin};
                    `RFC_OFS_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat};
                    `RFC_OFS_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask};
                    default:           wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    property p_trip_on_class;
        @(posedge clk_i) disable iff (rst_i)
        (win_end && (is_dc || is_ac)) |=> trip_o && state == RFC_TRIPPED;
    endproperty
    a_trip_on_class: assert property (p_trip_on_class) else $error("trip missing");

    property p_trip_hold;
        @(posedge clk_i) disable iff (rst_i)
        (trip_o && !released) |=> trip_o;
    endproperty
    a_trip_hold: assert property (p_trip_hold) else $error("trip dropped early");

    property p_release;
        @(posedge clk_i) disable iff (rst_i)
        released |=> !trip_o && state == RFC_IDLE;
    endproperty
    a_release: assert property (p_release) else $error("trip not released");

    property p_entry;
        @(posedge clk_i) disable iff (rst_i)
        (state == RFC_IDLE && enable && adc_valid_i && adc_data_i > entry_lvl)
            |=> state == RFC_MONITOR;
    endproperty
    a_entry: assert property (p_entry) else $error("monitor not entered");

    property p_window_len;
        @(posedge clk_i) disable iff (rst_i)
        $rose(state == RFC_MONITOR) |-> win_cnt == 32'h0000_0001;
    endproperty
    a_window_len: assert property (p_window_len) else $error("window count wrong");

    property p_extremes;
        @(posedge clk_i) disable iff (rst_i)
        (state == RFC_MONITOR && !win_end) |=> ext.smin <= ext.smax;
    endproperty
    a_extremes: assert property (p_extremes) else $error("extremes crossed");

    property p_dc_type;
        @(posedge clk_i) disable iff (rst_i)
        (win_end && is_dc) |=> fault == RFC_FAULT_DC;
    endproperty
    a_dc_type: assert property (p_dc_type) else $error("dc not stored");

    property p_ac_type;
        @(posedge clk_i) disable iff (rst_i)
        (win_end && !is_dc && is_ac) |=> fault == RFC_FAULT_AC;
    endproperty
    a_ac_type: assert property (p_ac_type) else $error("ac not stored");

    property p_no_fault;
        @(posedge clk_i) disable iff (rst_i)
        (win_end && !is_dc && !is_ac)
            |=> state == RFC_IDLE && !trip_o ##1 (ext.smax == 10'h000 || state == RFC_MONITOR);
    endproperty
    a_no_fault: assert property (p_no_fault) else $error("bad idle return");

    property p_entry_low;
        @(posedge clk_i) disable iff (rst_i)
        entry_lvl <= cfg.ac_thr && entry_lvl <= cfg.dc_thr;
    endproperty
    a_entry_low: assert property (p_entry_low) else $error("entry not lowest");

    property p_req_pace;
        @(posedge clk_i) disable iff (rst_i)
        adc_req_o |=> !adc_req_o;
    endproperty
    a_req_pace: assert property (p_req_pace) else $error("request too long");

    // relay follows the tripped state exactly, never a cycle apart
    property p_trip_state;
        @(posedge clk_i) disable iff (rst_i)
        trip_o == (state == RFC_TRIPPED);
    endproperty
    a_trip_state: assert property (p_trip_state) else $error("trip and state disagree");

    property p_win_close;
        @(posedge clk_i) disable iff (rst_i)
        win_end |=> state != RFC_MONITOR;
    endproperty
    a_win_close: assert property (p_win_close) else $error("window overran");

    property p_idle_stay;
        @(posedge clk_i) disable iff (rst_i)
        (state == RFC_IDLE && !(enable && adc_valid_i && adc_data_i > entry_lvl))
            |=> state == RFC_IDLE;
    endproperty
    a_idle_stay: assert property (p_idle_stay) else $error("idle left without entry");

    property p_req_due;
        @(posedge clk_i) disable iff (rst_i)
        (smp_cnt == SAMPLE_PER - 32'h0000_0001 && enable) |=> adc_req_o;
    endproperty
    a_req_due: assert property (p_req_due) else $error("sample request missing");

    // set must win over a write-one clear in the same cycle
    property p_irq_set;
        @(posedge clk_i) disable iff (rst_i)
        (irq_evt != '0) |=> (irq_stat & $past(irq_evt)) == $past(irq_evt);
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("event not recorded");

    property p_fault_hold;
        @(posedge clk_i) disable iff (rst_i)
        !(win_end && (is_dc || is_ac)) |=> $stable(fault);
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault type changed");

    property p_ext_track;
        @(posedge clk_i) disable iff (rst_i)
        (state == RFC_MONITOR && !win_end && adc_valid_i)
            |=> ext.smax >= $past(adc_data_i) && ext.smin <= $past(adc_data_i);
    endproperty
    a_ext_track: assert property (p_ext_track) else $error("sample outside extremes");
endmodule : rfc_core

`default_nettype wire

// *** testbench/rfc_adc_model.sv ***
// converter model: answers each sample request LAT+1 cycles later, sends samples on demand too
// assumes request and inject pulses come on clk_i, the classifier's own domain
`timescale 1ns/1ns
`default_nettype none

module rfc_adc_model #(
    parameter int LAT = 3
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       req_i,
    input  wire logic       inject_i,
    input  wire logic [9:0] level_i,
    output logic            valid_o,
    output logic [9:0]      data_o
);
    logic [LAT-1:0] pend;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend <= '0;
        end else begin
            pend <= {pend[LAT-2:0], req_i};
        end
    end

    // data wanders outside a valid so a stale code never passes for a sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
            data_o  <= 10'h000;
        end else begin
            valid_o <= pend[LAT-1] | inject_i;
            data_o  <= (pend[LAT-1] | inject_i) ? level_i : ~data_o;
        end
    end
endmodule : rfc_adc_model

`default_nettype wire

// *** testbench/tb.sv ***
// testbench for the residual fault classifier: wishbone master tasks, converter model
// assumes the window register is shortened to 100 cycles before fault scenarios
`include "rfc_params.svh"
`timescale 1ns/1ns
`default_nettype none

module tb;
    typedef struct packed {
        logic [5:0]  adr;
        logic [31:0] exp;
    } rfc_row_t;

    logic        clk, rst, cyc, stb, we, inj, ack, req, vld, trip, irq;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [9:0]  lvl, sdat;
    int          error_cnt, num_checks, wn;
    rfc_row_t    rows [10];

    rfc_core dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .adc_req_o(req), .adc_valid_i(vld), .adc_data_i(sdat), .trip_o(trip), .irq_o(irq));

    rfc_adc_model #(.LAT(3)) adc (.clk_i(clk), .rst_i(rst), .req_i(req), .inject_i(inj),
        .level_i(lvl), .valid_o(vld), .data_o(sdat));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        // no cycle limit here: only the watchdog ends a hung transfer
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : xfer

    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(q, exp);
    endtask : rd

    task automatic smp(input logic [9:0] v, input int k);
        repeat (k) begin
            @(posedge clk);
            inj <= 1'b1;
            lvl <= v;
            @(posedge clk);
            inj <= 1'b0;
        end
    endtask : smp

    task automatic wait_trip(input logic e);
        int n;
        n = 0;
        while (trip !== e && n < 400) begin
            @(posedge clk);
            n++;
        end
        check({31'h0, trip}, {31'h0, e});
    endtask : wait_trip

    task automatic complete_run();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // run needs about 25000 cycles
    initial begin
        #140000;
        error_cnt++;
        complete_run();
    end

    initial begin
        {rst, cyc, stb, we, inj} = 5'h10;
        adr  = 6'h00;
        sel  = 4'hf;
        wdat = 32'h0;
        lvl  = 10'h000;
        rows = '{'{6'h00, 32'h1}, '{6'h04, 32'h0}, '{6'h08, 32'h199}, '{6'h0c, 32'h88},
                 '{6'h10, 32'h8}, '{6'h14, 32'h10}, '{6'h18, 32'(`RFC_WINDOW_CYCLES)},
                 '{6'h1c, 32'h3ff}, '{6'h20, 32'h0}, '{6'h3c, 32'h0}};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check({30'h0, trip, irq}, 32'h0);
        foreach (rows[i]) begin
            rd(rows[i].adr, rows[i].exp);
        end
        xfer(1'b1, 6'h18, 32'h64);
        xfer(1'b1, 6'h24, 32'h7);
        // dc: eight samples of one code above the dc level at the start of the window
        smp(10'h100, 8);
        wait_trip(1'b1);
        rd(6'h04, 32'h19);
        rd(6'h20, 32'h1);
        check({31'h0, irq}, 32'h1);
        xfer(1'b1, 6'h20, 32'h1);
        rd(6'h20, 32'h0);
        check({31'h0, irq}, 32'h0);
        xfer(1'b1, 6'h24, 32'h3);
        // release level is 0x78: equal must not release
        smp(10'h078, 1);
        repeat (5) @(posedge clk);
        check({31'h0, trip}, 32'h1);
        smp(10'h077, 1);
        wait_trip(1'b0);
        rd(6'h04, 32'h10);
        rd(6'h20, 32'h4);
        check({31'h0, irq}, 32'h0);
        xfer(1'b1, 6'h24, 32'h7);
        rd(6'h20, 32'h4);
        check({31'h0, irq}, 32'h1);
        xfer(1'b1, 6'h20, 32'h7);
        // ac: minimum exactly at the near-zero level
        for (int i = 0; i < 4; i++) begin
            smp(10'h200, 1);
            smp(10'h008, 1);
        end
        rd(6'h1c, 32'h02000008);
        wait_trip(1'b1);
        rd(6'h04, 32'h29);
        smp(10'h000, 1);
        wait_trip(1'b0);
        xfer(1'b1, 6'h20, 32'h7);
        // ac level below dc level: entry must follow the lower one
        xfer(1'b1, 6'h08, 32'h50);
        xfer(1'b1, 6'h0c, 32'h300);
        smp(10'h050, 1);
        rd(6'h04, 32'h20);
        smp(10'h060, 1);
        rd(6'h04, 32'h24);
        rd(6'h1c, 32'h00600060);
        repeat (150) @(posedge clk);
        check({31'h0, trip}, 32'h0);
        rd(6'h04, 32'h20);
        rd(6'h1c, 32'h3ff);
        // write without byte lane 0 must be ignored
        sel <= 4'he;
        xfer(1'b1, 6'h08, 32'h123);
        sel <= 4'hf;
        rd(6'h08, 32'h50);
        // disabled block ignores a sample above the entry level
        xfer(1'b1, 6'h00, 32'h0);
        smp(10'h100, 1);
        rd(6'h04, 32'h20);
        xfer(1'b1, 6'h00, 32'h1);
        lvl <= 10'h010;
        wn = 0;
        while (req !== 1'b1 && wn < 26000) begin
            @(posedge clk);
            wn++;
        end
        check({31'h0, req}, 32'h1);
        @(posedge clk);
        check({31'h0, req}, 32'h0);
        // second reset in mid-run: settings go back to defaults
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check({31'h0, trip}, 32'h0);
        rd(6'h08, 32'h199);
        rd(6'h18, 32'(`RFC_WINDOW_CYCLES));
        complete_run();
    end
endmodule : tb

`default_nettype wire
